// ===== sfl_pkg.sv
// Behaviour
// - Rotate right through carry puts old carry in bit 7, shifts the rest down, moves bit 0 to carry and updates Z, C, N and V in one cycle.
// - Arithmetic shift right shifts bits 7..1 down into 6..0, keeps bit 7 and updates Z, C, N and V in one cycle.
// - Bit to transfer flag copies a chosen source bit into T, changes no other flag and takes one cycle.
// - Transfer flag to bit writes T into a chosen destination bit, changes no flag and takes one cycle.
// - Sign flag set and clear force S to one or zero alone, one cycle each.
// - Overflow set and clear force V to one or zero alone, one cycle each.
// - Half carry set and clear force H to one or zero alone, one cycle each.
// - Post-increment load reads memory at the pointer into the destination, then adds one to the pointer, in two cycles with no flag change.
// - Pre-decrement load subtracts one from the pointer first, then reads memory at the new address, in two cycles with no flag change.
// - Displaced load reads memory at pointer plus displacement, leaves the pointer alone, in two cycles with no flag change.
// - Direct load reads memory at the address carried by the instruction, in two cycles with no flag change.
// - Post-increment store writes the source to memory at the pointer, then adds one to the pointer, in two cycles with no flag change.
// - Pre-decrement store subtracts one from the pointer first, then writes the source there, in two cycles with no flag change.
package sfl_pkg;

   // Flag register bit positions
   localparam int unsigned FLAG_C = 0;
   localparam int unsigned FLAG_Z = 1;
   localparam int unsigned FLAG_N = 2;
   localparam int unsigned FLAG_V = 3;
   localparam int unsigned FLAG_S = 4;
   localparam int unsigned FLAG_H = 5;
   localparam int unsigned FLAG_T = 6;
   localparam int unsigned FLAG_I = 7;

   // Register file
   localparam int unsigned REG_COUNT = 32;
   localparam logic [4:0]  PTR_X_LO  = 5'h1A;
   localparam logic [4:0]  PTR_Y_LO  = 5'h1C;
   localparam logic [4:0]  PTR_Z_LO  = 5'h1E;

   // Reset values
   localparam logic [7:0]  FLAGS_RESET = 8'h00;
   localparam logic [7:0]  REG_RESET   = 8'h00;

   // Cycle counts
   localparam int unsigned CYCLES_SINGLE = 1;
   localparam int unsigned CYCLES_MEMORY = 2;

   // Pointer selection
   typedef enum logic [1:0] {
      ptr_x = 2'h0,
      ptr_y = 2'h1,
      ptr_z = 2'h2
   } sfl_ptr_type;

   // Operation codes
   typedef enum logic [4:0] {
      no_op                   = 5'h00,
      rotate_right_carry_op   = 5'h01,
      arith_shift_right_op    = 5'h02,
      nibble_exchange_op      = 5'h03,
      indexed_flag_set_op     = 5'h04,
      indexed_flag_clear_op   = 5'h05,
      bit_to_transfer_flag_op = 5'h06,
      transfer_flag_to_bit_op = 5'h07,
      sign_flag_set_op        = 5'h08,
      sign_flag_clear_op      = 5'h09,
      overflow_set_op         = 5'h0A,
      overflow_clear_op       = 5'h0B,
      half_carry_set_op       = 5'h0C,
      half_carry_clear_op     = 5'h0D,
      interrupt_enable_op     = 5'h0E,
      interrupt_disable_op    = 5'h0F,
      register_copy_op        = 5'h10,
      register_pair_copy_op   = 5'h11,
      immediate_load_op       = 5'h12,
      indirect_load_op        = 5'h13,
      indirect_load_inc_op    = 5'h14,
      indirect_load_dec_op    = 5'h15,
      displaced_load_op       = 5'h16,
      direct_load_op          = 5'h17,
      indirect_store_op       = 5'h18,
      indirect_store_inc_op   = 5'h19,
      indirect_store_dec_op   = 5'h1A
   } sfl_op_type;

   // Sequencer states
   typedef enum logic {
      st_idle   = 1'b0,
      st_memory = 1'b1
   } sfl_state_type;

endpackage

// ===== sfl_core.sv
`timescale 1ns/1ps
module sfl_core (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   // Instruction request
   input  wire logic        op_valid_i,
   input  wire logic [4:0]  op_code_i,
   input  wire logic [4:0]  op_dst_i,
   input  wire logic [4:0]  op_src_i,
   input  wire logic [2:0]  op_bit_i,
   input  wire logic [1:0]  op_ptr_i,
   input  wire logic [5:0]  op_disp_i,
   input  wire logic [7:0]  op_imm_i,
   input  wire logic [15:0] op_addr_i,
   output logic             op_ready_o,
   output logic             op_done_o,
   // Data memory
   output logic [15:0]      mem_addr_o,
   output logic [7:0]       mem_wdata_o,
   output logic             mem_re_o,
   output logic             mem_we_o,
   input  wire logic [7:0]  mem_rdata_i,
   // Observation
   input  wire logic [4:0]  peek_sel_i,
   output logic [7:0]       peek_data_o,
   output logic [7:0]       flags_o
);

   // Reset release
   logic rst_meta_reg;
   logic rst_sync_reg;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   function automatic logic [4:0] ptr_lo(input logic [1:0] sel);
      logic [4:0] idx;
      idx = sfl_pkg::PTR_X_LO;
      if (sel == sfl_pkg::ptr_y) begin
         idx = sfl_pkg::PTR_Y_LO;
      end else if (sel == sfl_pkg::ptr_z) begin
         idx = sfl_pkg::PTR_Z_LO;
      end
      return idx;
   endfunction

   function automatic logic [7:0] shift_flags(input logic [7:0] res, input logic cout, input logic [7:0] fl);
      logic [7:0] f;
      f = fl;
      f[sfl_pkg::FLAG_C] = cout;
      f[sfl_pkg::FLAG_Z] = (res == 8'h00);
      f[sfl_pkg::FLAG_N] = res[7];
      f[sfl_pkg::FLAG_V] = res[7] ^ cout;
      return f;
   endfunction

   // State
   logic [7:0]             rf_reg    [sfl_pkg::REG_COUNT];
   logic [7:0]             rf_next   [sfl_pkg::REG_COUNT];
   logic [7:0]             flag_reg;
   logic [7:0]             flag_next;
   sfl_pkg::sfl_state_type state_reg;
   sfl_pkg::sfl_state_type state_next;
   logic                   ready_reg;
   logic                   ready_next;
   logic                   done_reg;
   logic                   done_next;
   logic [15:0]            addr_reg;
   logic [15:0]            addr_next;
   logic [7:0]             wdata_reg;
   logic [7:0]             wdata_next;
   logic                   re_reg;
   logic                   re_next;
   logic                   we_reg;
   logic                   we_next;
   logic [4:0]             pend_dst_reg;
   logic [4:0]             pend_dst_next;
   logic [7:0]             peek_reg;
   logic [7:0]             peek_next;

   logic                   take;
   logic [7:0]             src_val;
   logic [7:0]             dst_val;
   logic [4:0]             plo;
   logic [15:0]            ptr_val;
   logic [15:0]            ptr_inc;
   logic [15:0]            ptr_dec;
   logic [7:0]             res;
   logic [4:0]             pair_d;
   logic [4:0]             pair_s;

   assign take    = op_valid_i && ready_reg;
   assign src_val = rf_reg[op_src_i];
   assign dst_val = rf_reg[op_dst_i];
   assign plo     = ptr_lo(op_ptr_i);
   assign ptr_val = {rf_reg[plo + 5'h01], rf_reg[plo]};
   assign ptr_inc = ptr_val + 16'h0001;
   assign ptr_dec = ptr_val - 16'h0001;
   assign pair_d  = {op_dst_i[4:1], 1'b0};
   assign pair_s  = {op_src_i[4:1], 1'b0};

   always_comb begin
      rf_next       = rf_reg;
      flag_next     = flag_reg;
      state_next    = state_reg;
      ready_next    = 1'b1;
      done_next     = 1'b0;
      addr_next     = addr_reg;
      wdata_next    = wdata_reg;
      re_next       = 1'b0;
      we_next       = 1'b0;
      pend_dst_next = pend_dst_reg;
      peek_next     = rf_reg[peek_sel_i];
      res           = 8'h00;
      unique case (state_reg)
         sfl_pkg::st_idle: begin
            if (take) begin
               done_next = 1'b1;
               unique case (op_code_i)
                  sfl_pkg::rotate_right_carry_op: begin
                     res = {flag_reg[sfl_pkg::FLAG_C], dst_val[7:1]};
                     rf_next[op_dst_i] = res;
                     flag_next = shift_flags(res, dst_val[0], flag_reg);
                  end
                  sfl_pkg::arith_shift_right_op: begin
                     res = {dst_val[7], dst_val[7:1]};
                     rf_next[op_dst_i] = res;
                     flag_next = shift_flags(res, dst_val[0], flag_reg);
                  end
                  sfl_pkg::nibble_exchange_op: rf_next[op_dst_i] = {dst_val[3:0], dst_val[7:4]};
                  sfl_pkg::indexed_flag_set_op: flag_next[op_bit_i] = 1'b1;
                  sfl_pkg::indexed_flag_clear_op: flag_next[op_bit_i] = 1'b0;
                  sfl_pkg::bit_to_transfer_flag_op: flag_next[sfl_pkg::FLAG_T] = src_val[op_bit_i];
                  sfl_pkg::transfer_flag_to_bit_op: rf_next[op_dst_i][op_bit_i] = flag_reg[sfl_pkg::FLAG_T];
                  sfl_pkg::sign_flag_set_op: flag_next[sfl_pkg::FLAG_S] = 1'b1;
                  sfl_pkg::sign_flag_clear_op: flag_next[sfl_pkg::FLAG_S] = 1'b0;
                  sfl_pkg::overflow_set_op: flag_next[sfl_pkg::FLAG_V] = 1'b1;
                  sfl_pkg::overflow_clear_op: flag_next[sfl_pkg::FLAG_V] = 1'b0;
                  sfl_pkg::half_carry_set_op: flag_next[sfl_pkg::FLAG_H] = 1'b1;
                  sfl_pkg::half_carry_clear_op: flag_next[sfl_pkg::FLAG_H] = 1'b0;
                  sfl_pkg::interrupt_enable_op: flag_next[sfl_pkg::FLAG_I] = 1'b1;
                  sfl_pkg::interrupt_disable_op: flag_next[sfl_pkg::FLAG_I] = 1'b0;
                  sfl_pkg::register_copy_op: rf_next[op_dst_i] = src_val;
                  sfl_pkg::register_pair_copy_op: begin
                     rf_next[pair_d]         = rf_reg[pair_s];
                     rf_next[pair_d + 5'h01] = rf_reg[pair_s + 5'h01];
                  end
                  sfl_pkg::immediate_load_op: rf_next[op_dst_i] = op_imm_i;
                  sfl_pkg::indirect_load_op,
                  sfl_pkg::indirect_load_inc_op,
                  sfl_pkg::indirect_load_dec_op,
                  sfl_pkg::displaced_load_op,
                  sfl_pkg::direct_load_op: begin
                     done_next     = 1'b0;
                     ready_next    = 1'b0;
                     state_next    = sfl_pkg::st_memory;
                     re_next       = 1'b1;
                     pend_dst_next = op_dst_i;
                     addr_next     = ptr_val;
                     if (op_code_i == sfl_pkg::indirect_load_inc_op) begin
                        {rf_next[plo + 5'h01], rf_next[plo]} = ptr_inc;
                     end else if (op_code_i == sfl_pkg::indirect_load_dec_op) begin
                        addr_next = ptr_dec;
                        {rf_next[plo + 5'h01], rf_next[plo]} = ptr_dec;
                     end else if (op_code_i == sfl_pkg::displaced_load_op) begin
                        addr_next = ptr_val + {10'h000, op_disp_i};
                     end else if (op_code_i == sfl_pkg::direct_load_op) begin
                        addr_next = op_addr_i;
                     end
                  end
                  sfl_pkg::indirect_store_op,
                  sfl_pkg::indirect_store_inc_op,
                  sfl_pkg::indirect_store_dec_op: begin
                     done_next  = 1'b0;
                     ready_next = 1'b0;
                     state_next = sfl_pkg::st_memory;
                     we_next    = 1'b1;
                     wdata_next = src_val;
                     addr_next  = ptr_val;
                     if (op_code_i == sfl_pkg::indirect_store_inc_op) begin
                        {rf_next[plo + 5'h01], rf_next[plo]} = ptr_inc;
                     end else if (op_code_i == sfl_pkg::indirect_store_dec_op) begin
                        addr_next = ptr_dec;
                        {rf_next[plo + 5'h01], rf_next[plo]} = ptr_dec;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         sfl_pkg::st_memory: begin
            if (re_reg) begin
               rf_next[pend_dst_reg] = mem_rdata_i;
            end
            done_next  = 1'b1;
            ready_next = 1'b1;
            state_next = sfl_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         for (int i = 0; i < sfl_pkg::REG_COUNT; i++) begin
            rf_reg[i] <= sfl_pkg::REG_RESET;
         end
         flag_reg     <= sfl_pkg::FLAGS_RESET;
         state_reg    <= sfl_pkg::st_idle;
         ready_reg    <= 1'b0;
         done_reg     <= 1'b0;
         addr_reg     <= 16'h0000;
         wdata_reg    <= 8'h00;
         re_reg       <= 1'b0;
         we_reg       <= 1'b0;
         pend_dst_reg <= 5'h00;
         peek_reg     <= 8'h00;
      end else begin
         rf_reg       <= rf_next;
         flag_reg     <= flag_next;
         state_reg    <= state_next;
         ready_reg    <= ready_next;
         done_reg     <= done_next;
         addr_reg     <= addr_next;
         wdata_reg    <= wdata_next;
         re_reg       <= re_next;
         we_reg       <= we_next;
         pend_dst_reg <= pend_dst_next;
         peek_reg     <= peek_next;
      end
   end

   assign op_ready_o  = ready_reg;
   assign op_done_o   = done_reg;
   assign mem_addr_o  = addr_reg;
   assign mem_wdata_o = wdata_reg;
   assign mem_re_o    = re_reg;
   assign mem_we_o    = we_reg;
   assign peek_data_o = peek_reg;
   assign flags_o     = flag_reg;

   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_sync_reg);

   property p_rotate;
      logic [7:0] d;
      logic       c;
      logic [4:0] r;
      (take && op_code_i == sfl_pkg::rotate_right_carry_op, d = dst_val, c = flag_reg[sfl_pkg::FLAG_C], r = op_dst_i)
      |=> rf_reg[r] == {c, d[7:1]} && flag_reg[sfl_pkg::FLAG_C] == d[0];
   endproperty
   a_rotate: assert property (p_rotate) else $error("rotate result wrong");

   property p_ashift;
      logic [7:0] d;
      logic [4:0] r;
      (take && op_code_i == sfl_pkg::arith_shift_right_op, d = dst_val, r = op_dst_i)
      |=> rf_reg[r] == {d[7], d[7:1]} && flag_reg[sfl_pkg::FLAG_N] == d[7];
   endproperty
   a_ashift: assert property (p_ashift) else $error("arithmetic shift wrong");

   property p_tstore;
      (take && op_code_i == sfl_pkg::bit_to_transfer_flag_op)
      |=> flag_reg[sfl_pkg::FLAG_T] == $past(src_val[op_bit_i])
          && flag_reg[5:0] == $past(flag_reg[5:0]) && flag_reg[7] == $past(flag_reg[7]);
   endproperty
   a_tstore: assert property (p_tstore) else $error("transfer flag copy wrong");

   property p_tload;
      logic [4:0] r;
      logic [2:0] b;
      (take && op_code_i == sfl_pkg::transfer_flag_to_bit_op, r = op_dst_i, b = op_bit_i)
      |=> rf_reg[r][b] == flag_reg[sfl_pkg::FLAG_T] && $stable(flag_reg);
   endproperty
   a_tload: assert property (p_tload) else $error("bit load from transfer flag wrong");

   property p_sign;
      (take && op_code_i == sfl_pkg::sign_flag_set_op) |=> flag_reg[sfl_pkg::FLAG_S] && op_done_o;
   endproperty
   a_sign: assert property (p_sign) else $error("sign flag not set");

   property p_overflow;
      (take && op_code_i == sfl_pkg::overflow_clear_op) |=> !flag_reg[sfl_pkg::FLAG_V]
         && flag_reg[2:0] == $past(flag_reg[2:0]);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow flag not cleared");

   property p_half;
      (take && op_code_i == sfl_pkg::half_carry_set_op) |=> flag_reg[sfl_pkg::FLAG_H]
         && flag_reg[4:0] == $past(flag_reg[4:0]);
   endproperty
   a_half: assert property (p_half) else $error("half carry flag not set");

   property p_load_inc;
      logic [15:0] p;
      logic [4:0]  l;
      (take && op_code_i == sfl_pkg::indirect_load_inc_op, p = ptr_val, l = plo)
      |=> mem_re_o && mem_addr_o == p && {rf_reg[l + 5'h01], rf_reg[l]} == p + 16'h0001 ##1 op_done_o;
   endproperty
   a_load_inc: assert property (p_load_inc) else $error("post-increment load wrong");

   property p_load_dec;
      logic [15:0] p;
      (take && op_code_i == sfl_pkg::indirect_load_dec_op, p = ptr_val)
      |=> mem_re_o && mem_addr_o == p - 16'h0001 && !op_ready_o;
   endproperty
   a_load_dec: assert property (p_load_dec) else $error("pre-decrement load address wrong");

   property p_load_data;
      logic [4:0] r;
      (state_reg == sfl_pkg::st_memory && re_reg, r = pend_dst_reg)
      |=> rf_reg[r] == $past(mem_rdata_i) && op_ready_o && $stable(flag_reg);
   endproperty
   a_load_data: assert property (p_load_data) else $error("loaded byte not written");

   property p_store_dec;
      logic [7:0] s;
      logic [15:0] p;
      (take && op_code_i == sfl_pkg::indirect_store_dec_op, s = src_val, p = ptr_val)
      |=> mem_we_o && mem_wdata_o == s && mem_addr_o == p - 16'h0001 ##1 !mem_we_o && op_done_o;
   endproperty
   a_store_dec: assert property (p_store_dec) else $error("pre-decrement store wrong");

endmodule

// ===== sfl_mem_model.sv
`timescale 1ns/1ps
module sfl_mem_model (
   // Clock
   input  wire logic        ref_clk_i,
   // Memory port
   input  wire logic [15:0] mem_addr_i,
   input  wire logic [7:0]  mem_wdata_i,
   input  wire logic        mem_re_i,
   input  wire logic        mem_we_i,
   output logic [7:0]       mem_rdata_o
);
   logic [7:0] store_reg [256];
   logic [7:0] last_reg;

   initial begin
      for (int i = 0; i < 256; i++) begin
         store_reg[i] = 8'(i) ^ 8'h5A;
      end
      last_reg = 8'h00;
   end

   // Data only valid in the strobe cycle, else inverted
   always_comb begin
      mem_rdata_o = mem_re_i ? store_reg[mem_addr_i[7:0]] : ~last_reg;
   end

   always @(posedge ref_clk_i) begin
      if (mem_re_i) begin
         last_reg <= mem_rdata_o;
      end
      if (mem_we_i) begin
         store_reg[mem_addr_i[7:0]] <= mem_wdata_i;
      end
   end
endmodule

// ===== shift_flag_load_store_execution_tb.sv
`timescale 1ns/1ps
module shift_flag_load_store_execution_tb;
   logic        ref_clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        op_valid_i = 1'b0;
   logic [4:0]  op_code_i = 5'h00;
   logic [4:0]  op_dst_i = 5'h00;
   logic [4:0]  op_src_i = 5'h00;
   logic [2:0]  op_bit_i = 3'h0;
   logic [1:0]  op_ptr_i = 2'h0;
   logic [5:0]  op_disp_i = 6'h00;
   logic [7:0]  op_imm_i = 8'h00;
   logic [15:0] op_addr_i = 16'h0000;
   logic [4:0]  peek_sel_i = 5'h00;
   logic        op_ready_o, op_done_o, mem_re_o, mem_we_o;
   logic [15:0] mem_addr_o;
   logic [7:0]  mem_wdata_o, mem_rdata_i, peek_data_o, flags_o;
   logic [7:0]  rf [32];
   logic [7:0]  mexp [256];
   logic [7:0]  fl;
   logic [4:0]  rop, rs;
   logic [1:0]  rp;
   int          fail_count = 0;
   int          check_count = 0;
   int          seed = 24010;

   always #2 ref_clk_i = ~ref_clk_i;

   sfl_core i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
      .op_dst_i(op_dst_i), .op_src_i(op_src_i), .op_bit_i(op_bit_i), .op_ptr_i(op_ptr_i), .op_disp_i(op_disp_i),
      .op_imm_i(op_imm_i), .op_addr_i(op_addr_i), .op_ready_o(op_ready_o), .op_done_o(op_done_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_re_o(mem_re_o), .mem_we_o(mem_we_o),
      .mem_rdata_i(mem_rdata_i), .peek_sel_i(peek_sel_i), .peek_data_o(peek_data_o), .flags_o(flags_o));

   sfl_mem_model i_mem (.ref_clk_i(ref_clk_i), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
      .mem_re_i(mem_re_o), .mem_we_i(mem_we_o), .mem_rdata_o(mem_rdata_i));

   task test_done;
      $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task check_val(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task peek_chk(input logic [4:0] idx);
      peek_sel_i = idx;
      @(negedge ref_clk_i);
      check_val({8'h00, peek_data_o}, {8'h00, rf[idx]});
   endtask

   task run_op(input logic [4:0] op, d, s, input logic [2:0] b, input logic [1:0] p,
               input logic [5:0] q, input logic [7:0] k, input logic [15:0] a);
      int          n;
      logic [7:0]  r, v, res;
      logic [15:0] ptr, ma;
      logic [4:0]  lo;
      logic        mem, wr;
      lo = 5'h1A + {1'b0, p, 1'b0};
      ptr = {rf[lo + 5'h01], rf[lo]};
      ma = ptr;
      r = rf[d];
      v = rf[s];
      mem = (op >= sfl_pkg::indirect_load_op) && (op <= sfl_pkg::indirect_store_dec_op);
      wr = (op >= sfl_pkg::indirect_store_op) && (op <= sfl_pkg::indirect_store_dec_op);
      case (op)
         sfl_pkg::rotate_right_carry_op, sfl_pkg::arith_shift_right_op: begin
            res = {(op == sfl_pkg::arith_shift_right_op) ? r[7] : fl[0], r[7:1]};
            fl[0] = r[0];
            fl[1] = (res == 8'h00);
            fl[2] = res[7];
            fl[3] = res[7] ^ r[0];
            rf[d] = res;
         end
         sfl_pkg::nibble_exchange_op: rf[d] = {r[3:0], r[7:4]};
         sfl_pkg::indexed_flag_set_op: fl[b] = 1'b1;
         sfl_pkg::indexed_flag_clear_op: fl[b] = 1'b0;
         sfl_pkg::bit_to_transfer_flag_op: fl[6] = v[b];
         sfl_pkg::transfer_flag_to_bit_op: rf[d][b] = fl[6];
         sfl_pkg::sign_flag_set_op: fl[4] = 1'b1;
         sfl_pkg::sign_flag_clear_op: fl[4] = 1'b0;
         sfl_pkg::overflow_set_op: fl[3] = 1'b1;
         sfl_pkg::overflow_clear_op: fl[3] = 1'b0;
         sfl_pkg::half_carry_set_op: fl[5] = 1'b1;
         sfl_pkg::half_carry_clear_op: fl[5] = 1'b0;
         sfl_pkg::interrupt_enable_op: fl[7] = 1'b1;
         sfl_pkg::interrupt_disable_op: fl[7] = 1'b0;
         sfl_pkg::register_copy_op: rf[d] = v;
         sfl_pkg::register_pair_copy_op: begin
            r = rf[{s[4:1], 1'b0}];
            res = rf[{s[4:1], 1'b1}];
            rf[{d[4:1], 1'b0}] = r;
            rf[{d[4:1], 1'b1}] = res;
         end
         sfl_pkg::immediate_load_op: rf[d] = k;
         sfl_pkg::indirect_load_inc_op, sfl_pkg::indirect_store_inc_op: ptr = ptr + 16'h0001;
         sfl_pkg::indirect_load_dec_op, sfl_pkg::indirect_store_dec_op: begin
            ptr = ptr - 16'h0001;
            ma = ptr;
         end
         sfl_pkg::displaced_load_op: ma = ptr + {10'h000, q};
         sfl_pkg::direct_load_op: ma = a;
         default: ;
      endcase
      if (mem) begin
         {rf[lo + 5'h01], rf[lo]} = ptr;
         if (wr) begin
            mexp[ma[7:0]] = v;
         end else begin
            rf[d] = mexp[ma[7:0]];
         end
      end
      for (n = 0; n < 10 && op_ready_o !== 1'b1; n++) begin
         @(negedge ref_clk_i);
      end
      if (n == 10) begin
         fail_count++;
         test_done();
      end
      op_code_i = op;
      op_dst_i = d;
      op_src_i = s;
      op_bit_i = b;
      op_ptr_i = p;
      op_disp_i = q;
      op_imm_i = k;
      op_addr_i = a;
      op_valid_i = 1'b1;
      repeat (sfl_pkg::CYCLES_SINGLE) @(negedge ref_clk_i);
      op_valid_i = 1'b0;
      if (mem) begin
         check_val({14'h0000, mem_re_o, mem_we_o}, {14'h0000, !wr, wr});
         check_val(mem_addr_o, ma);
         if (wr) check_val({8'h00, mem_wdata_o}, {8'h00, v});
         check_val({14'h0000, op_ready_o, op_done_o}, 16'h0000);
         repeat (sfl_pkg::CYCLES_MEMORY - sfl_pkg::CYCLES_SINGLE) @(negedge ref_clk_i);
      end
      check_val({15'h0000, op_done_o}, 16'h0001);
      check_val({8'h00, flags_o}, {8'h00, fl});
      peek_chk(d);
      peek_chk(d ^ 5'h01);
      if (mem) peek_chk(lo);
      if (mem) peek_chk(lo + 5'h01);
   endtask

   initial begin
      fl = 8'h00;
      for (int i = 0; i < 256; i++) begin
         mexp[i] = 8'(i) ^ 8'h5A;
      end
      for (int i = 0; i < 32; i++) begin
         rf[i] = 8'h00;
      end
      repeat (8) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      for (int i = 0; i < 32; i++) begin
         peek_chk(5'(i));
      end
      check_val({8'h00, flags_o}, 16'h0000);
      for (int i = 0; i < 32; i++) begin
         run_op(sfl_pkg::immediate_load_op, 5'(i), 5'h00, 3'h0, 2'h0, 6'h00, 8'($random(seed)), 16'h0000);
      end
      for (int i = 0; i < 700; i++) begin
         rop = 5'($unsigned($random(seed)) % 28);
         rs = 5'($random(seed));
         rp = 2'($unsigned($random(seed)) % 3);
         if (rop >= sfl_pkg::indirect_store_op && rop <= sfl_pkg::indirect_store_dec_op) rs = rs % 5'd26;
         if (rop == sfl_pkg::displaced_load_op && rp == 2'h0) rp = 2'h2;
         run_op(rop, 5'($random(seed)), rs, 3'($random(seed)), rp, 6'($random(seed)), 8'($random(seed)),
                16'($random(seed)));
      end
      rst_b_i = 1'b0;
      repeat (2) @(negedge ref_clk_i);
      rst_b_i = 1'b1;
      fl = sfl_pkg::FLAGS_RESET;
      for (int i = 0; i < 32; i++) begin
         rf[i] = sfl_pkg::REG_RESET;
         peek_chk(5'(i));
      end
      check_val({8'h00, flags_o}, {8'h00, fl});
      run_op(sfl_pkg::interrupt_enable_op, 5'h00, 5'h00, 3'h0, 2'h0, 6'h00, 8'h00, 16'h0000);
      test_done();
   end
endmodule
